//--- rtl/sfdpt_pkg.sv
// ============================================================================
// Sfdpt package
// ============================================================================
// Holds the byte addresses, byte values, link states and state types of the
// upper parameter table. It assumes nothing of its surroundings.

package sfdpt_pkg;

  // ==========================================================================
  // Widths and link counts
  // ==========================================================================
  localparam int unsigned SFDPT_AW       = 8;
  localparam int unsigned SFDPT_DW       = 8;
  localparam int unsigned SFDPT_UID_W    = 64;
  localparam logic [2:0]  SFDPT_BIT_LAST = 3'h7;
  localparam logic [2:0]  SFDPT_BIT_STEP = 3'h1;
  localparam logic [7:0]  SFDPT_ADDR_STEP = 8'h01;
  localparam logic [15:0] SFDPT_CNT_STEP = 16'h0001;

  // ==========================================================================
  // Byte addresses
  // ==========================================================================
  localparam logic [7:0] SFDPT_A_QIO_SET = 8'h88;
  localparam logic [7:0] SFDPT_A_QIO_OP  = 8'h89;
  localparam logic [7:0] SFDPT_A_QO_SET  = 8'h8A;
  localparam logic [7:0] SFDPT_A_QO_OP   = 8'h8B;
  localparam logic [7:0] SFDPT_A_DO_SET  = 8'h8C;
  localparam logic [7:0] SFDPT_A_DO_OP   = 8'h8D;
  localparam logic [7:0] SFDPT_A_DIO_SET = 8'h8E;
  localparam logic [7:0] SFDPT_A_DIO_OP  = 8'h8F;
  localparam logic [7:0] SFDPT_A_UWP_LO  = 8'h90;
  localparam logic [7:0] SFDPT_A_UWP_HI  = 8'h93;
  localparam logic [7:0] SFDPT_A_D2_LO   = 8'h94;
  localparam logic [7:0] SFDPT_A_D4_HI   = 8'h9B;
  localparam logic [7:0] SFDPT_A_ER1_SZ  = 8'h9C;
  localparam logic [7:0] SFDPT_A_ER1_OP  = 8'h9D;
  localparam logic [7:0] SFDPT_A_ER2_SZ  = 8'h9E;
  localparam logic [7:0] SFDPT_A_ER2_OP  = 8'h9F;
  localparam logic [7:0] SFDPT_A_ER3_SZ  = 8'hA0;
  localparam logic [7:0] SFDPT_A_ER3_OP  = 8'hA1;
  localparam logic [7:0] SFDPT_A_ER4_SZ  = 8'hA2;
  localparam logic [7:0] SFDPT_A_ER4_OP  = 8'hA3;
  localparam logic [7:0] SFDPT_A_RSV_LO  = 8'hA4;
  localparam logic [7:0] SFDPT_A_RSV_HI  = 8'hF7;
  localparam logic [7:0] SFDPT_A_UID_LO  = 8'hF8;

  // ==========================================================================
  // Byte values
  // ==========================================================================
  localparam logic [7:0]  SFDPT_V_QIO_SET = 8'h44;
  localparam logic [7:0]  SFDPT_V_QIO_OP  = 8'hEB;
  localparam logic [7:0]  SFDPT_V_QO_SET  = 8'h08;
  localparam logic [7:0]  SFDPT_V_QO_OP   = 8'h6B;
  localparam logic [7:0]  SFDPT_V_DO_SET  = 8'h08;
  localparam logic [7:0]  SFDPT_V_DO_OP   = 8'h3B;
  localparam logic [7:0]  SFDPT_V_DIO_SET = 8'h80;
  localparam logic [7:0]  SFDPT_V_DIO_OP  = 8'hBB;
  localparam logic [31:0] SFDPT_V_UWP     = 32'hFFFF_FFEE;
  localparam logic [7:0]  SFDPT_V_ER1_SZ  = 8'h0C;
  localparam logic [7:0]  SFDPT_V_ER1_OP  = 8'h20;
  localparam logic [7:0]  SFDPT_V_ER2_SZ  = 8'h10;
  localparam logic [7:0]  SFDPT_V_ER2_OP  = 8'hD8;
  localparam logic [7:0]  SFDPT_V_ER_NONE = 8'h00;
  localparam logic [7:0]  SFDPT_V_FILL    = 8'hFF;

  // ==========================================================================
  // Link states and state types
  // ==========================================================================
  typedef enum logic {
    SFDPT_PH_ADDR = 1'b0,
    SFDPT_PH_DATA = 1'b1
  } sfdpt_phase_e;

  typedef struct packed {
    sfdpt_phase_e phase;
    logic [2:0]   bit_cnt;
    logic [7:0]   addr;
    logic [7:0]   shreg;
  } sfdpt_link_s;

  typedef struct packed {
    logic miso;
    logic miso_oe_b;
  } sfdpt_out_s;

  typedef struct packed {
    logic [2:0]  cs_sync;
    logic [2:0]  srv_sync;
    logic        frame_active;
    logic        serving;
    logic [15:0] frame_count;
  } sfdpt_sys_s;

  localparam sfdpt_link_s SFDPT_LINK_RST = '{
    phase: SFDPT_PH_ADDR, bit_cnt: 3'h0, addr: 8'h00, shreg: 8'h00};
  localparam sfdpt_out_s SFDPT_OUT_RST = '{miso: 1'b0, miso_oe_b: 1'b1};
  localparam sfdpt_sys_s SFDPT_SYS_RST = '{
    cs_sync: 3'h7, srv_sync: 3'h0, frame_active: 1'b0, serving: 1'b0,
    frame_count: 16'h0000};

endpackage : sfdpt_pkg

//--- rtl/sfdpt_rom.sv
// ============================================================================
// Sfdpt table lookup
// ============================================================================
// Holds the constant byte table from 88h to FFh, answering combinationally.
// Assumes a steady address from the link logic on the serial clock.
`timescale 1ns/100ps

module sfdpt_rom
  import sfdpt_pkg::*;
#(
  parameter logic [63:0] UNIQUE_ID = 64'h0123_4567_89AB_CDEF  // arbitrary
) (
  input  wire logic [7:0] addr,
  output logic      [7:0] data
);

  // Byte lookup; anything not named here reads as filler
  always_comb begin
    data = SFDPT_V_FILL;
    if (addr >= SFDPT_A_UID_LO) begin
      data = UNIQUE_ID[{addr[2:0], 3'h0} +: 8];
    end else if (addr >= SFDPT_A_RSV_LO && addr <= SFDPT_A_RSV_HI) begin
      data = SFDPT_V_FILL;
    end else if (addr >= SFDPT_A_UWP_LO && addr <= SFDPT_A_UWP_HI) begin
      data = SFDPT_V_UWP[{addr[1:0], 3'h0} +: 8];
    end else if (addr >= SFDPT_A_D2_LO && addr <= SFDPT_A_D4_HI) begin
      data = SFDPT_V_FILL;
    end else begin
      unique case (addr)
        SFDPT_A_QIO_SET: data = SFDPT_V_QIO_SET;
        SFDPT_A_QIO_OP:  data = SFDPT_V_QIO_OP;
        SFDPT_A_QO_SET:  data = SFDPT_V_QO_SET;
        SFDPT_A_QO_OP:   data = SFDPT_V_QO_OP;
        SFDPT_A_DO_SET:  data = SFDPT_V_DO_SET;
        SFDPT_A_DO_OP:   data = SFDPT_V_DO_OP;
        SFDPT_A_DIO_SET: data = SFDPT_V_DIO_SET;
        SFDPT_A_DIO_OP:  data = SFDPT_V_DIO_OP;
        SFDPT_A_ER1_SZ:  data = SFDPT_V_ER1_SZ;
        SFDPT_A_ER1_OP:  data = SFDPT_V_ER1_OP;
        SFDPT_A_ER2_SZ:  data = SFDPT_V_ER2_SZ;
        SFDPT_A_ER2_OP:  data = SFDPT_V_ER2_OP;
        SFDPT_A_ER3_SZ:  data = SFDPT_V_ER_NONE;
        SFDPT_A_ER3_OP:  data = SFDPT_V_FILL;
        SFDPT_A_ER4_SZ:  data = SFDPT_V_ER_NONE;
        SFDPT_A_ER4_OP:  data = SFDPT_V_FILL;
        default:         data = SFDPT_V_FILL;
      endcase
    end
  end

endmodule // sfdpt_rom

//--- rtl/sfdpt_top.sv
// ============================================================================
// Sfdpt top: serial read port of the upper parameter table
// ============================================================================
// Holds the serial link logic, the table lookup and the system-side status.
// Assumes a host that frames each read with spi_cs_b low, sends an 8-bit
// byte address MSB first on rising spi_sck, then samples data MSB first on
// rising spi_sck; spi_sck may stop whenever spi_cs_b is high.
`timescale 1ns/100ps

module sfdpt_top
  import sfdpt_pkg::*;
#(
  parameter logic [63:0] UNIQUE_ID = 64'h0123_4567_89AB_CDEF  // arbitrary
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        spi_sck,
  input  wire logic        spi_cs_b,
  input  wire logic        spi_mosi,
  output logic             spi_miso,
  output logic             spi_miso_oe_b,
  output logic             frame_active,
  output logic             data_serving,
  output logic      [15:0] frame_count
);

  // ==========================================================================
  // State
  // ==========================================================================
  sfdpt_link_s link_reg;
  sfdpt_link_s link_next;
  sfdpt_out_s  out_reg;
  sfdpt_out_s  out_next;
  sfdpt_sys_s  sys_reg;
  sfdpt_sys_s  sys_next;
  logic [7:0]  rom_addr;
  logic [7:0]  rom_data;

  // ==========================================================================
  // Table lookup
  // ==========================================================================
  sfdpt_rom #(
    .UNIQUE_ID (UNIQUE_ID)
  ) u_rom (
    .addr (rom_addr),
    .data (rom_data)
  );

  // ==========================================================================
  // Link domain, rising serial clock
  // ==========================================================================
  // Address of the byte to load next: the one being completed, or the
  // following byte while streaming (wraps at FFh)
  always_comb begin
    if (link_reg.phase == SFDPT_PH_ADDR) begin
      rom_addr = {link_reg.addr[6:0], spi_mosi};
    end else begin
      rom_addr = link_reg.addr + SFDPT_ADDR_STEP;
    end
  end

  // Address shift, then byte load and data shift
  always_comb begin
    link_next         = link_reg;
    link_next.bit_cnt = link_reg.bit_cnt + SFDPT_BIT_STEP;
    unique case (link_reg.phase)
      SFDPT_PH_ADDR: begin
        link_next.addr = rom_addr;
        if (link_reg.bit_cnt == SFDPT_BIT_LAST) begin
          link_next.phase = SFDPT_PH_DATA;
          link_next.shreg = rom_data;
        end
      end
      SFDPT_PH_DATA: begin
        if (link_reg.bit_cnt == SFDPT_BIT_LAST) begin
          link_next.addr  = rom_addr;
          link_next.shreg = rom_data;
        end else begin
          link_next.shreg = {link_reg.shreg[6:0], 1'b0};
        end
      end
    endcase
  end

  // Frame end clears the link at once; the clock may already have stopped
  always_ff @(posedge spi_sck or posedge spi_cs_b) begin
    if (spi_cs_b) begin
      link_reg <= SFDPT_LINK_RST;
    end else begin
      link_reg <= link_next;
    end
  end

  // ==========================================================================
  // Link domain, falling serial clock
  // ==========================================================================
  // Data bit and drive enable change half a clock before host sampling
  always_comb begin
    out_next.miso      = link_reg.shreg[7];
    out_next.miso_oe_b = (link_reg.phase != SFDPT_PH_DATA);
  end

  always_ff @(negedge spi_sck or posedge spi_cs_b) begin
    if (spi_cs_b) begin
      out_reg <= SFDPT_OUT_RST;
    end else begin
      out_reg <= out_next;
    end
  end

  // ==========================================================================
  // System domain
  // ==========================================================================
  // Three-stage level syncs; a change counts once stages two and three agree
  always_comb begin
    sys_next          = sys_reg;
    sys_next.cs_sync  = {sys_reg.cs_sync[1:0], spi_cs_b};
    sys_next.srv_sync = {sys_reg.srv_sync[1:0], link_reg.phase};
    if (sys_reg.cs_sync[1] == sys_reg.cs_sync[2]) begin
      sys_next.frame_active = !sys_reg.cs_sync[2];
    end
    if (sys_reg.srv_sync[1] == sys_reg.srv_sync[2]) begin
      sys_next.serving = sys_reg.srv_sync[2];
      if (sys_reg.srv_sync[2] && !sys_reg.serving) begin
        sys_next.frame_count = sys_reg.frame_count + SFDPT_CNT_STEP;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sys_reg <= SFDPT_SYS_RST;
    end else begin
      sys_reg <= sys_next;
    end
  end

  // ==========================================================================
  // Outputs, straight from flip-flops
  // ==========================================================================
  assign spi_miso      = out_reg.miso;
  assign spi_miso_oe_b = out_reg.miso_oe_b;
  assign frame_active  = sys_reg.frame_active;
  assign data_serving  = sys_reg.serving;
  assign frame_count   = sys_reg.frame_count;

endmodule // sfdpt_top

//--- testbench/sfdpt_top_asserts.sv
// Checker for the serial table port and its status outputs.
// Bound to sfdpt_top; sees only its ports.
`timescale 1ns/100ps

module sfdpt_top_asserts (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        spi_sck,
  input wire logic        spi_cs_b,
  input wire logic        spi_mosi,
  input wire logic        spi_miso,
  input wire logic        spi_miso_oe_b,
  input wire logic        frame_active,
  input wire logic        data_serving,
  input wire logic [15:0] frame_count
);
  logic [3:0] rise_cnt_reg;

  // ==============
  // Link rises seen in this frame, held at 8
  always_ff @(posedge spi_sck or posedge spi_cs_b) begin
    if (spi_cs_b)
      rise_cnt_reg <= 4'h0;
    else if (rise_cnt_reg != 4'h8)
      rise_cnt_reg <= rise_cnt_reg + 4'h1;
  end

  // ==============
  // Link side
  AST_OE_ADDR: assert property (@(posedge spi_sck) disable iff (spi_cs_b)
    rise_cnt_reg < 4'h8 |-> spi_miso_oe_b) else $error("driven in address");
  AST_OE_DATA: assert property (@(posedge spi_sck) disable iff (spi_cs_b)
    rise_cnt_reg == 4'h8 |-> !spi_miso_oe_b) else $error("not driven");
  AST_OE_IDLE: assert property (@(posedge clk) disable iff (!rst_b)
    spi_cs_b |-> spi_miso_oe_b) else $error("driven while deselected");
  AST_MISO_IDLE: assert property (@(posedge clk) disable iff (!rst_b)
    spi_cs_b |-> !spi_miso) else $error("data while deselected");

  // ==============
  // System status
  AST_FRAME_UP: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(spi_cs_b) |-> ##[2:4] frame_active) else $error("frame late");
  AST_FRAME_DN: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(spi_cs_b) |-> ##[2:4] !frame_active) else $error("frame stuck");
  AST_SERVE_DN: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(spi_cs_b) |-> ##[2:5] !data_serving) else $error("serving stuck");
  AST_CNT_STEP: assert property (@(posedge clk) disable iff (!rst_b)
    $changed(frame_count) |-> frame_count == $past(frame_count) + 16'h0001)
    else $error("count jump");
  AST_CNT_ON_SERVE: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(data_serving) |-> ##[0:1] $changed(frame_count))
    else $error("count missed");

  // Main scenarios reached
  C_SERVE: cover property (@(posedge clk) $rose(data_serving));
  C_DATA: cover property (@(posedge spi_sck) rise_cnt_reg == 4'h8);
  C_FRAMES: cover property (@(posedge clk) frame_count == 16'h0004);
endmodule // sfdpt_top_asserts

bind sfdpt_top sfdpt_top_asserts i_sfdpt_top_asserts (
  .clk(clk), .rst_b(rst_b), .spi_sck(spi_sck), .spi_cs_b(spi_cs_b),
  .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe_b(spi_miso_oe_b),
  .frame_active(frame_active), .data_serving(data_serving),
  .frame_count(frame_count));

//--- testbench/sfdpt_host.sv
// Host model: frames reads on the serial link.
// Link clock runs only inside frames, 15 ns period.
`timescale 1ns/100ps

module sfdpt_host (
  output logic spi_sck,
  output logic spi_cs_b,
  output logic spi_mosi,
  input  wire logic spi_miso,
  input  wire logic spi_miso_oe_b
);
  logic [7:0] rx_q [$];
  int         oe_err;

  // Idle link, clock stopped
  initial begin
    spi_sck = 1'b0;
    spi_cs_b = 1'b1;
    spi_mosi = 1'b1;
    oe_err = 0;
  end

  // Address MSB first, then nb-8 data bits; partial byte dropped
  task automatic rd(input logic [7:0] a, input int nb);
    logic [7:0] b;
    rx_q.delete();
    spi_cs_b = 1'b0;
    for (int k = 0; k < nb; k++) begin
      spi_mosi = (k < 8) ? a[7-k] : ~spi_mosi; // Toggles once released
      #7.5 spi_sck = 1'b1;
      if (k >= 8) begin
        b = {b[6:0], spi_miso};
        if (spi_miso_oe_b !== 1'b0)
          oe_err++;
        if (k % 8 == 7)
          rx_q.push_back(b);
      end
      #7.5 spi_sck = 1'b0;
    end
    #7.5 spi_cs_b = 1'b1;
  endtask
endmodule // sfdpt_host

//--- testbench/tb_sfdpt_top.sv
// Self-checking bench for sfdpt_top.
// Reset on clk; the host model drives the link.
`timescale 1ns/100ps

module tb_sfdpt_top;
  localparam logic [63:0] UID = 64'h5A3C_96E1_0F7B_D248; // arbitrary
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  wire         spi_sck, spi_cs_b, spi_mosi, spi_miso, spi_miso_oe_b;
  logic        frame_active, data_serving;
  logic [15:0] frame_count;
  logic [15:0] n_frm = 16'h0000;
  int          n_fail = 0;
  int          samples_checked = 0;
  logic [7:0]  lo_t [0:27] = '{8'h44, 8'hEB, 8'h08, 8'h6B, 8'h08, 8'h3B,
    8'h80, 8'hBB, 8'hEE, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0C, 8'h20, 8'h10, 8'hD8, 8'h00, 8'hFF,
    8'h00, 8'hFF};
  logic [2:0]  md [0:3] = '{3'h2, 3'h0, 3'h0, 3'h4};
  logic [4:0]  dm [0:3] = '{5'h04, 5'h08, 5'h08, 5'h00};

  // ==============
  // Clock and instances
  always #50 clk = ~clk;

  sfdpt_top #(.UNIQUE_ID(UID)) i_sfdpt_top (.clk(clk), .rst_b(rst_b),
    .spi_sck(spi_sck), .spi_cs_b(spi_cs_b), .spi_mosi(spi_mosi),
    .spi_miso(spi_miso), .spi_miso_oe_b(spi_miso_oe_b),
    .frame_active(frame_active), .data_serving(data_serving),
    .frame_count(frame_count));
  sfdpt_host i_sfdpt_host (.spi_sck(spi_sck), .spi_cs_b(spi_cs_b),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .spi_miso_oe_b(spi_miso_oe_b));

  // ==============
  // Expected table byte
  function automatic logic [7:0] exp_b(input logic [7:0] a);
    if (a >= 8'hF8)
      return UID[8*(a-8'hF8) +: 8];
    if (a >= 8'h88 && a <= 8'hA3)
      return lo_t[a-8'h88];
    return 8'hFF;
  endfunction

  task automatic chk_v(input logic [15:0] got, exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // One frame, then status settles
  task automatic frame(input logic [7:0] a, input int nb);
    i_sfdpt_host.rd(a, nb);
    repeat (6) @(negedge clk);
    n_frm++;
    chk_v(frame_count, n_frm, "count");
    chk_v({14'h0000, frame_active, data_serving}, 16'h0000, "idle");
    chk_v(16'(i_sfdpt_host.oe_err), 16'h0000, "drive");
  endtask

  // Whole bytes from a, each against the table
  task automatic burst(input logic [7:0] a, input int n);
    frame(a, 8 + 8*n);
    chk_v(16'(i_sfdpt_host.rx_q.size()), 16'(n), "length");
    foreach (i_sfdpt_host.rx_q[i])
      chk_v({8'h00, i_sfdpt_host.rx_q[i]}, {8'h00, exp_b(a+8'(i))}, "byte");
  endtask

  // ==============
  // Scenarios
  task automatic t_set;
    burst(8'h88, 8);
    for (int k = 0; k < 4; k++) begin
      chk_v({13'h0000, i_sfdpt_host.rx_q[2*k][7:5]}, {13'h0000, md[k]},
        "mode");
      chk_v({11'h0000, i_sfdpt_host.rx_q[2*k][4:0]}, {11'h0000, dm[k]},
        "dummy");
    end
  endtask

  task automatic t_words;
    burst(8'h90, 12);
    burst(8'h9C, 8);
    burst(8'hF6, 11);
  endtask

  task automatic t_abort;
    frame(8'h89, 20);
    chk_v({8'h00, i_sfdpt_host.rx_q[0]}, 16'h00EB, "partial");
  endtask

  task automatic t_reset;
    @(posedge clk) rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    n_frm = 16'h0000;
    @(negedge clk);
    chk_v(frame_count, 16'h0000, "reset count");
    burst(8'h8E, 2);
  endtask

  task automatic conclude;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(negedge clk);
    t_set();
    t_words();
    t_abort();
    t_reset();
    conclude();
  end

  // Watchdog
  initial begin
    #200000;
    n_fail++;
    $display("[FAIL] %0t watchdog", $time);
    conclude();
  end
endmodule // tb_sfdpt_top
